// file: rtl/sadc_device.sv
// Purpose: Converter-side serial port and conversion sequencer.
// Assumes: Link inputs synchronous to hclk; edges found by compare.
// Notes: Analog inputs are 12-bit codes scaled to the reference.
// Functional notes
// - Drive on falling, sample on rising edge
// - Select low starts; high resets the port
// - Single-input: output enabled on second pulse
// - One null bit before the result
// - First one after select is start bit
// - Three configuration bits follow the start bit
// - Ignore data input after configuration
// - Capture configuration on rising clock edge
// - Select/odd bits choose channels and polarity
// - Order one: MSB first then zeros
// - Order zero: MSB first then LSB first
// - Single-input always sends both orders
// - Zeros forever after transfer completes
// - Analog powers down on the fall that drives B0 of the MSB-first result
// - Powered only while select is low
// - Straight binary unipolar 12-bit code
// - Host may share one data wire
// - Device drives line on fourth fall
// - Hold and convert on fall after order bit
module sadc_device (
    input wire logic hclk,
    input wire logic hresetn,
    sadc_if.device link,
    input wire logic single_input_variant,
    input wire logic [11:0] analog_input_zero,
    input wire logic [11:0] analog_input_one,
    output logic analog_powered,
    output logic [11:0] held_sample
);
    // Edge detection on the shift clock
    logic sclk_prev_reg;
    wire sclk_rise = link.shift_clk & !sclk_prev_reg;
    wire sclk_fall = !link.shift_clk & sclk_prev_reg;
    wire sel_n = link.select_shutdown_n;

    // Sequencer state
    sadc_pkg::sadc_dev_state_type state_reg, state_next;
    logic [2:0] cfg_reg, cfg_next; // {single-ended, odd, order}
    logic [1:0] cfg_cnt_reg, cfg_cnt_next; // Config bits taken
    logic [1:0] fall_cnt_reg, fall_cnt_next; // Falls since select
    logic [3:0] idx_reg, idx_next; // Output bit position
    logic dout_reg, dout_next; // Serial output bit
    logic doe_n_reg, doe_n_next; // Output enable, low drives
    logic powered_reg, powered_next; // Bias and comparator on
    logic [11:0] held_reg, held_next; // Held sample
    logic hold_now; // Sample taken this cycle
    logic sar_step; // Advance approximation

    // Configuration fields
    wire single_ended_select = cfg_reg[2];
    wire odd_sign = cfg_reg[1];
    wire msb_only_order = cfg_reg[0];

    // Channel routing; single-input variant leaves cfg at zero
    wire [11:0] pos_code = odd_sign ? analog_input_one : analog_input_zero;
    wire [11:0] neg_code = odd_sign ? analog_input_zero : analog_input_one;
    wire pos_wins = (pos_code >= neg_code);
    wire [11:0] diff_code = pos_wins ? 12'(pos_code - neg_code) : 12'h000;
    // Unipolar only: negative differences clip to zero
    wire [11:0] sample_code = single_ended_select ? pos_code : diff_code;

    // Successive approximation engine
    wire sar_bit;
    wire [11:0] sar_result;
    sadc_sar u_sar (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(hold_now),
        .step(sar_step),
        .sample(held_reg),
        .bit_now(sar_bit),
        .result_reg(sar_result)
    );

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        cfg_next = cfg_reg;
        cfg_cnt_next = cfg_cnt_reg;
        fall_cnt_next = fall_cnt_reg;
        idx_next = idx_reg;
        dout_next = dout_reg;
        doe_n_next = doe_n_reg;
        held_next = held_reg;
        hold_now = 1'b0;
        sar_step = 1'b0;
        if (sel_n) begin
            // Select high: port reset, output released
            state_next = sadc_pkg::DEV_IDLE;
            doe_n_next = 1'b1;
            dout_next = 1'b0;
        end else begin
            case (state_reg)
                sadc_pkg::DEV_IDLE: begin
                    // Fresh exchange; defaults give differential 0-1
                    state_next = sadc_pkg::DEV_HUNT;
                    cfg_next = 3'h0;
                    cfg_cnt_next = 2'h0;
                    fall_cnt_next = 2'h0;
                end
                sadc_pkg::DEV_HUNT: begin
                    if (single_input_variant) begin
                        // No config word; count falls to the enable
                        if (sclk_fall) begin
                            fall_cnt_next = 2'(fall_cnt_reg + 2'h1);
                            if (2'(fall_cnt_reg + 2'h1) == sadc_pkg::SGL_HOLD_FALL) begin
                                hold_now = 1'b1;
                            end
                        end
                    end else if (sclk_rise && link.data_line) begin
                        // Leading zeros skipped, first one starts
                        state_next = sadc_pkg::DEV_CONFIG;
                    end
                end
                sadc_pkg::DEV_CONFIG: begin
                    // Shift in three configuration bits on rises
                    if (sclk_rise) begin
                        cfg_next = {cfg_reg[1:0], link.data_line};
                        cfg_cnt_next = 2'(cfg_cnt_reg + 2'h1);
                        if (cfg_cnt_reg == sadc_pkg::CFG_LAST) begin
                            state_next = sadc_pkg::DEV_ARM;
                        end
                    end
                end
                sadc_pkg::DEV_ARM: begin
                    // Fall after order bit: hold, take the line
                    if (sclk_fall) begin
                        hold_now = 1'b1;
                    end
                end
                sadc_pkg::DEV_CONV: begin
                    // One decision per fall, MSB downward
                    if (sclk_fall) begin
                        sar_step = 1'b1;
                        dout_next = sar_bit;
                        if (idx_reg == 4'h0) begin
                            // Order one ends in zeros, else LSB run
                            idx_next = sadc_pkg::LSBF_START;
                            if (msb_only_order) begin
                                state_next = sadc_pkg::DEV_ZERO;
                            end else begin
                                state_next = sadc_pkg::DEV_LSBF;
                            end
                        end else begin
                            idx_next = idx_reg - 4'h1;
                        end
                    end
                end
                sadc_pkg::DEV_LSBF: begin
                    // B0 is shared; LSB-first run continues with B1
                    if (sclk_fall) begin
                        dout_next = sar_result[idx_reg];
                        if (idx_reg == sadc_pkg::MSB_IDX) begin
                            state_next = sadc_pkg::DEV_ZERO;
                        end else begin
                            idx_next = idx_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    // Transfer done: zeros while clocking goes on
                    if (sclk_fall) begin
                        dout_next = 1'b0;
                    end
                end
            endcase
            // Common hold action: enable output with a null bit
            if (hold_now) begin
                held_next = sample_code;
                doe_n_next = 1'b0;
                dout_next = 1'b0;
                idx_next = sadc_pkg::MSB_IDX;
                state_next = sadc_pkg::DEV_CONV;
            end
        end
    end

    // Analog active from select fall until conversion ends
    always_comb begin
        case (state_next)
            sadc_pkg::DEV_HUNT, sadc_pkg::DEV_CONFIG,
            sadc_pkg::DEV_ARM, sadc_pkg::DEV_CONV: powered_next = !sel_n;
            default: powered_next = 1'b0;
        endcase
    end

    // Link edge tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= link.shift_clk;
        end
    end

    // Sequencer registers; config shifts in DEV_CONFIG, is cleared in DEV_IDLE, else holds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= sadc_pkg::DEV_IDLE;
            cfg_reg <= 3'h0;
            cfg_cnt_reg <= 2'h0;
            fall_cnt_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            cfg_cnt_reg <= cfg_cnt_next;
            fall_cnt_reg <= fall_cnt_next;
        end
    end

    // Output path registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_reg <= 4'h0;
            dout_reg <= 1'b0;
            doe_n_reg <= 1'b1;
            powered_reg <= 1'b0;
            held_reg <= 12'h000;
        end else begin
            idx_reg <= idx_next;
            dout_reg <= dout_next;
            doe_n_reg <= doe_n_next;
            powered_reg <= powered_next;
            held_reg <= held_next;
        end
    end

    // Link and user outputs
    assign link.dev_data_out = dout_reg;
    assign link.dev_data_oe_n = doe_n_reg;
    assign analog_powered = powered_reg;
    assign held_sample = held_reg;
endmodule : sadc_device

// file: rtl/sadc_pkg.sv
// Purpose: Shared constants and types for the serial converter port.
// Assumes: One 50 MHz clock on both ends; shift clock made by the host.
// Notes: Link counts and register offsets live here; the SAR keeps its own start weight.
package sadc_pkg;
    // Result and configuration word sizes
    localparam int RES_BITS = 12;
    localparam logic [1:0] CFG_LAST = 2'h2;
    localparam logic [3:0] MSB_IDX = 4'hB;
    localparam logic [3:0] LSBF_START = 4'h1;
    // Falling edge that holds the sample in the single-input variant
    localparam logic [1:0] SGL_HOLD_FALL = 2'h2;
    // System clock and shift clock half period
    localparam int CLK_PERIOD_NS = 20;
    localparam int SHIFT_HALF_NS = 2500;
    localparam logic [7:0] SHIFT_HALF_CYC = 8'(SHIFT_HALF_NS / CLK_PERIOD_NS);
    // Host pulse indices (pulse 0 carries the start bit)
    localparam logic [4:0] FIRST_B11_CFG = 5'h05;
    localparam logic [4:0] FIRST_B11_SGL = 5'h03;
    localparam logic [4:0] RELEASE_PULSE = 5'h03;
    localparam logic [4:0] MSB_SPAN = 5'h0B;
    localparam logic [4:0] FULL_SPAN = 5'h16;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] RES_OFS = 8'h08;
    // Control field positions
    localparam int CTRL_GO = 0;
    localparam int CTRL_SGL = 1;
    localparam int CTRL_ODD = 2;
    localparam int CTRL_MSB_ONLY_ORDER = 3;
    localparam int CTRL_NOCFG = 4;
    // Status and result field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int RES_LSBF_POS = 16;
    // Device sequencer states
    typedef enum {
        DEV_IDLE, DEV_HUNT, DEV_CONFIG, DEV_ARM, DEV_CONV, DEV_LSBF, DEV_ZERO
    } sadc_dev_state_type;
    // Host sequencer states
    typedef enum {HOST_IDLE, HOST_RUN, HOST_FIN} sadc_host_state_type;
endpackage : sadc_pkg

// file: rtl/sadc_if.sv
// Purpose: Serial link between host and converter port.
// Assumes: All signals are driven from hclk flip-flops.
// Notes: Data line resolves to the driving party, else reads low.
interface sadc_if;
    logic select_shutdown_n; // Active-low select, also shutdown
    logic shift_clk; // Shift clock from the host
    logic host_data_out; // Host bit onto the data line
    logic host_data_oe_n; // Low while host drives
    logic dev_data_out; // Device bit onto the data line
    logic dev_data_oe_n; // Low while device drives
    logic data_line; // Resolved shared data wire
    // Device wins if both drive; that would be a host fault
    assign data_line = !dev_data_oe_n ? dev_data_out :
                       (!host_data_oe_n ? host_data_out : 1'b0);
    // Converter end
    modport device (
        input select_shutdown_n,
        input shift_clk,
        input data_line,
        output dev_data_out,
        output dev_data_oe_n
    );
    // Controller end
    modport host (
        output select_shutdown_n,
        output shift_clk,
        output host_data_out,
        output host_data_oe_n,
        input data_line
    );
endinterface : sadc_if

// file: rtl/sadc_sar.sv
// Purpose: Successive-approximation register, one decision per step.
// Assumes: Sample stays held from load until the last step.
// Notes: Decision bit is combinational; caller registers it.
module sadc_sar (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic step,
    input wire logic [11:0] sample,
    output logic bit_now,
    output logic [11:0] result_reg
);
    logic [11:0] trial_reg; // One-hot weight under test
    logic [11:0] result_next;
    logic [11:0] trial_next;
    wire [11:0] trial_code = result_reg | trial_reg;

    // Comparator: keep the weight if the sample reaches it
    assign bit_now = (sample >= trial_code);

    // Next weight and result
    always_comb begin
        result_next = result_reg;
        trial_next = trial_reg;
        if (load) begin
            result_next = 12'h000;
            trial_next = 12'h800;
        end else if (step) begin
            result_next = bit_now ? trial_code : result_reg;
            trial_next = trial_reg >> 1;
        end
    end

    // State
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_reg <= 12'h000;
            trial_reg <= 12'h000;
        end else begin
            result_reg <= result_next;
            trial_reg <= trial_next;
        end
    end
endmodule : sadc_sar

// file: rtl/sadc_host.sv
// Purpose: Host controller driving the converter link from AHB-Lite.
// Assumes: Single word transfers; zero wait states, OKAY only.
// Notes: Shift clock is divided from hclk; one exchange per go.
module sadc_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    sadc_if.host link
);
    // Bus data-phase tracking
    logic wr_pend_reg; // Write data phase due
    logic [7:0] addr_reg; // Latched address
    wire take = hsel & htrans[1] & hready;
    wire wr_ctrl = wr_pend_reg && (addr_reg == sadc_pkg::CTRL_OFS);
    wire wr_stat = wr_pend_reg && (addr_reg == sadc_pkg::STAT_OFS);

    // Link state
    sadc_pkg::sadc_host_state_type state_reg, state_next;
    logic [3:0] cfg_reg, cfg_next; // {no-config, order, odd, single-ended}
    logic done_reg, done_next; // Sticky exchange complete
    logic [11:0] msb_reg, msb_next; // MSB-first result
    logic [11:0] lsb_reg, lsb_next; // LSB-first run, B11..B1
    logic cs_n_reg, cs_n_next;
    logic sclk_reg, sclk_next;
    logic hdout_reg, hdout_next;
    logic hoe_n_reg, hoe_n_next;
    logic [7:0] div_reg, div_next;
    logic [4:0] pulse_reg, pulse_next;

    // Pulse bookkeeping
    wire tick = (div_reg == 8'(sadc_pkg::SHIFT_HALF_CYC - 8'h01));
    wire [4:0] first = cfg_reg[3] ? sadc_pkg::FIRST_B11_SGL : sadc_pkg::FIRST_B11_CFG;
    wire [4:0] rel = pulse_reg - first;
    // Order bit sits at cfg_reg[2]; it picks the span, cfg_reg[3] the first B11 pulse
    wire [4:0] span = cfg_reg[2] ? sadc_pkg::MSB_SPAN : sadc_pkg::FULL_SPAN;
    wire in_msb = (pulse_reg >= first) && (rel <= sadc_pkg::MSB_SPAN);
    wire in_lsb = (pulse_reg >= first) && (rel > sadc_pkg::MSB_SPAN);
    wire [4:0] pulse_inc = pulse_reg + 5'h01;
    // Config word bit for the coming pulse: single-ended, odd, then order
    wire tx_bit = (pulse_inc == 5'h01) ? cfg_reg[0] :
                  (pulse_inc == 5'h02) ? cfg_reg[1] : cfg_reg[2];
    wire go = wr_ctrl && hwdata[sadc_pkg::CTRL_GO] && (state_reg == sadc_pkg::HOST_IDLE);
    wire finish = (state_reg == sadc_pkg::HOST_FIN) && tick;

    // Link sequencer next state
    always_comb begin
        state_next = state_reg;
        cfg_next = cfg_reg;
        msb_next = msb_reg;
        lsb_next = lsb_reg;
        cs_n_next = cs_n_reg;
        sclk_next = sclk_reg;
        hdout_next = hdout_reg;
        hoe_n_next = hoe_n_reg;
        pulse_next = pulse_reg;
        div_next = tick ? 8'h00 : div_reg + 8'h01;
        case (state_reg)
            sadc_pkg::HOST_IDLE: begin
                div_next = 8'h00;
                if (go) begin
                    // Select low starts the exchange; start bit set up
                    cfg_next = hwdata[sadc_pkg::CTRL_NOCFG:sadc_pkg::CTRL_SGL];
                    cs_n_next = 1'b0;
                    hdout_next = 1'b1;
                    hoe_n_next = hwdata[sadc_pkg::CTRL_NOCFG];
                    pulse_next = 5'h00;
                    lsb_next = 12'h000;
                    state_next = sadc_pkg::HOST_RUN;
                end
            end
            sadc_pkg::HOST_RUN: begin
                if (tick && !sclk_reg) begin
                    // Rising edge: incoming bit sampled
                    sclk_next = 1'b1;
                    if (in_msb) begin
                        msb_next = {msb_reg[10:0], link.data_line};
                    end else if (in_lsb) begin
                        lsb_next = {link.data_line, lsb_reg[11:1]};
                    end
                end else if (tick) begin
                    // Falling edge: next bit driven
                    sclk_next = 1'b0;
                    pulse_next = pulse_inc;
                    hdout_next = tx_bit;
                    // Release before the device takes the line
                    if (pulse_reg == sadc_pkg::RELEASE_PULSE) begin
                        hoe_n_next = 1'b1;
                    end
                    // Stop after B0 if only MSB-first wanted
                    if (rel == span && pulse_reg >= first) begin
                        state_next = sadc_pkg::HOST_FIN;
                        pulse_next = pulse_reg;
                    end
                end
            end
            default: begin
                if (tick) begin
                    // Raise select: device resets and powers down
                    cs_n_next = 1'b1;
                    hoe_n_next = 1'b1;
                    state_next = sadc_pkg::HOST_IDLE;
                end
            end
        endcase
    end

    // Done: set wins over a same-cycle clear
    assign done_next = finish | (done_reg & ~(wr_stat & hwdata[sadc_pkg::STAT_DONE]));

    // Bus phase registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take & hwrite;
            addr_reg <= take ? haddr[7:0] : addr_reg;
        end
    end

    // Sequencer registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= sadc_pkg::HOST_IDLE;
            cfg_reg <= 4'h0;
            done_reg <= 1'b0;
            msb_reg <= 12'h000;
            lsb_reg <= 12'h000;
            pulse_reg <= 5'h00;
            div_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            done_reg <= done_next;
            msb_reg <= msb_next;
            lsb_reg <= lsb_next;
            pulse_reg <= pulse_next;
            div_reg <= div_next;
        end
    end

    // Pin registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            hdout_reg <= 1'b0;
            hoe_n_reg <= 1'b1;
        end else begin
            cs_n_reg <= cs_n_next;
            sclk_reg <= sclk_next;
            hdout_reg <= hdout_next;
            hoe_n_reg <= hoe_n_next;
        end
    end

    // Read mux; B0 completes the LSB-first word
    wire busy = (state_reg != sadc_pkg::HOST_IDLE);
    wire [31:0] ctrl_word = {27'h0, cfg_reg, 1'b0};
    wire [31:0] stat_word = {30'h0, done_reg, busy};
    wire [31:0] res_word = {4'h0, lsb_reg[11:1], msb_reg[0], 4'h0, msb_reg};
    assign hrdata = (addr_reg == sadc_pkg::CTRL_OFS) ? ctrl_word :
                    (addr_reg == sadc_pkg::STAT_OFS) ? stat_word :
                    (addr_reg == sadc_pkg::RES_OFS) ? res_word : 32'h0;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.select_shutdown_n = cs_n_reg;
    assign link.shift_clk = sclk_reg;
    assign link.host_data_out = hdout_reg;
    assign link.host_data_oe_n = hoe_n_reg;
endmodule : sadc_host

// file: tb/sadc_link_monitor.sv
// Purpose: Checks the serial link between host and converter ends.
// Assumes: All link signals change on hclk edges only.
// Notes: Sees the wire only, no register state.
module sadc_link_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic select_shutdown_n,
    input wire logic shift_clk,
    input wire logic host_data_out,
    input wire logic host_data_oe_n,
    input wire logic dev_data_out,
    input wire logic dev_data_oe_n,
    input wire logic data_line
);
    default clocking mon_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Selected phase of the exchange
    wire sel = !select_shutdown_n;
    a_clk_idle_low: assert property (select_shutdown_n |-> !shift_clk)
        else $error("shift clock high while deselected");
    a_dev_release: assert property ($rose(select_shutdown_n) |-> ##[1:2] dev_data_oe_n)
        else $error("device kept the line after deselect");
    a_host_idle_off: assert property (select_shutdown_n && $past(select_shutdown_n) |-> host_data_oe_n)
        else $error("host drives line while deselected");
    a_no_contention: assert property (!(!host_data_oe_n && !dev_data_oe_n))
        else $error("both ends drive the data line");
    a_dev_late_on: assert property ($fell(select_shutdown_n) |-> dev_data_oe_n [*8])
        else $error("device drove line too early");
    a_null_bit_low: assert property ($fell(dev_data_oe_n) |-> !dev_data_out)
        else $error("first device bit not low");
    // Hazard: a change while the clock is high would race the sampling edge
    a_dev_on_fall: assert property (sel && !dev_data_oe_n && $changed(dev_data_out) |-> !shift_clk)
        else $error("device bit changed with clock high");
    a_host_on_fall: assert property (sel && !host_data_oe_n && $changed(host_data_out) |-> !shift_clk)
        else $error("host bit changed with clock high");
    a_line_taken_low: assert property ($fell(dev_data_oe_n) |-> !data_line)
        else $error("shared line not low when device took it");
endmodule : sadc_link_monitor

// file: tb/tb_top.sv
// Purpose: Drives host registers over AHB-Lite against a converter end.
// Assumes: Zero wait states; one exchange per go.
// Notes: Expected results go to a queue checked by a watcher.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic hreadyout, hresp, powered, variant = 1'b0, chk_res = 1'b0;
    logic [31:0] hrdata, rd;
    logic [11:0] ain0 = 12'h000, ain1 = 12'h000, held, code;
    logic [32:0] note;
    logic [32:0] exp_q[$]; // Mask flag, then expected result word
    logic [4:0] ctl;
    int num_errors = 0, n_compared = 0, k, seed = 32'h97c772a8;
    sadc_if link ();
    always #10 hclk = ~hclk;
    sadc_host i_sadc_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
    sadc_device i_sadc_device (.hclk(hclk), .hresetn(hresetn), .link(link),
        .single_input_variant(variant), .analog_input_zero(ain0), .analog_input_one(ain1),
        .analog_powered(powered), .held_sample(held));
    sadc_link_monitor i_sadc_link_monitor (.hclk(hclk), .hresetn(hresetn),
        .select_shutdown_n(link.select_shutdown_n), .shift_clk(link.shift_clk),
        .host_data_out(link.host_data_out), .host_data_oe_n(link.host_data_oe_n),
        .dev_data_out(link.dev_data_out), .dev_data_oe_n(link.dev_data_oe_n),
        .data_line(link.data_line));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One single transfer; address phase then data phase
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        chk_res <= !wr && a == sadc_pkg::RES_OFS;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk_res <= 1'b0;
    endtask : ahb
    // Unipolar code: differential below zero clips to zero
    function automatic logic [11:0] expect_code(input logic [4:0] c);
        logic [12:0] d;
        d = c[2] ? {1'b0, ain1} - {1'b0, ain0} : {1'b0, ain0} - {1'b0, ain1};
        if (c[1] && !c[4]) begin
            return c[2] ? ain1 : ain0;
        end
        return d[12] ? 12'h000 : d[11:0];
    endfunction : expect_code
    task give_verdict;
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // Watcher: every result read is matched to the oldest note
    always @(posedge hclk) begin
        if (chk_res) begin
            note = exp_q.pop_front();
            check(hrdata & (note[32] ? 32'h0000_0FFF : 32'hFFFF_FFFF), note[31:0]);
        end
    end
    // All channel and order codes, then the no-config variant both ways
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            ctl = (i < 8) ? {1'b0, 3'(i), 1'b1} : {1'b1, 1'(i), 3'h1};
            @(posedge hclk);
            ain0 <= 12'($random(seed));
            ain1 <= 12'($random(seed));
            variant <= ctl[4];
            ahb(1'b1, sadc_pkg::CTRL_OFS, {27'h0, ctl});
            k = 0;
            do begin
                ahb(1'b0, sadc_pkg::STAT_OFS, 32'h0);
                k++;
                if (k == 1) check({31'h0, powered}, 32'h1);
            end while (rd[sadc_pkg::STAT_DONE] !== 1'b1 && k < 5000);
            check({31'h0, rd[sadc_pkg::STAT_DONE]}, 32'h1);
            code = expect_code(ctl);
            // MSB-only runs are masked to the low word, so expect zeros above
            exp_q.push_back({ctl[3], 4'h0, ctl[3] ? 12'h000 : code, 4'h0, code});
            ahb(1'b0, sadc_pkg::RES_OFS, 32'h0);
            check({20'h0, held}, {20'h0, code});
            check({31'h0, powered}, 32'h0);
            ahb(1'b0, sadc_pkg::CTRL_OFS, 32'h0);
            check(rd, {27'h0, ctl[4:1], 1'b0});
            ahb(1'b1, sadc_pkg::STAT_OFS, 32'h2);
        end
        ahb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0);
        check({31'h0, hresp}, 32'h0);
        give_verdict();
    end
    // Watchdog, margin over the expected run yet under the cycle budget
    initial begin
        #1_800_000;
        num_errors++;
        give_verdict();
    end
endmodule : tb_top
